// ### mpfc_flow_ctrl.sv
// mac pause flow-control unit with its control register
// Summary of operation
// - programmed pause time goes into every generated pause frame.
// - generated frames follow the standard pause frame field layout.
// - full duplex: busy high from frame start until sent on cable.
// - half duplex: busy reads high while back pressure is asserted.
// - busy clears by itself when the pause frame completes.
// - pass bit sets or clears packet-filter bit for valid pause frames.
// - every received frame's data is forwarded regardless of settings.
// - active filtering modes override the pass bit in status.
// - enable in full duplex decodes pause frames and halts transmitter.
// - enable clear: no control decode and no pause halting.
// - half duplex: enable turns on back pressure.
// - transmitter disabled: no pause frames, no back pressure.
// - flow-control requests come from an external configuration input.
// - 32-bit register, reset zero, bits 15 to 3 reserved.
//
// The strobed register port was left to the implementer.
module mpfc_flow_ctrl #(
    parameter int ADDR_W = 4
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_full_duplex,
    input wire logic i_speed_100,
    input wire logic i_tx_enable,
    input wire logic i_auto_pause_config,
    input wire logic [47:0] i_src_addr,
    output mpfc_pkg::mpfc_tx_s o_tx,
    input wire logic i_tx_ready,
    input wire logic i_tx_done,
    input wire mpfc_pkg::mpfc_rx_s i_rx,
    input wire logic i_filt_override,
    input wire logic i_addr_filt_bit,
    output mpfc_pkg::mpfc_rx_s o_rx_fwd,
    output logic o_rx_stat_valid,
    output logic o_rx_pkt_filter,
    output logic o_tx_halt,
    output logic o_backpressure
);
    import mpfc_pkg::*;

    if (ADDR_W < 4 || ADDR_W > 16) begin : g_bad_addr_w
        $error("mpfc_flow_ctrl: ADDR_W must be 4 to 16");
    end

    // ------------------------------------------------------------
    // frame byte functions
    // ------------------------------------------------------------
    function automatic logic [7:0] hdr_byte(input logic [5:0] idx);
        logic [7:0] b;
        b = 8'h00;
        if (idx < SA_POS) begin
            b = PAUSE_DA[8'(47 - 8 * idx) -: 8];
        end else if (idx == TYPE_POS) begin
            b = CTRL_TYPE[15:8];
        end else if (idx == TYPE_POS + 6'h01) begin
            b = CTRL_TYPE[7:0];
        end else if (idx == OPC_POS) begin
            b = PAUSE_OPC[15:8];
        end else if (idx == OPC_POS + 6'h01) begin
            b = PAUSE_OPC[7:0];
        end
        return b;
    endfunction : hdr_byte

    function automatic logic [7:0] frame_byte(input logic [5:0] idx,
        input logic [15:0] pt, input logic [47:0] sa);
        logic [7:0] b;
        b = hdr_byte(idx);
        if (idx >= SA_POS && idx < TYPE_POS) begin
            b = sa[8'(47 - 8 * (idx - SA_POS)) -: 8];
        end else if (idx == PT_POS) begin
            b = pt[15:8];
        end else if (idx == PT_POS + 6'h01) begin
            b = pt[7:0];
        end
        return b;
    endfunction : frame_byte

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    typedef enum {TX_IDLE, TX_SEND, TX_WAIT} mpfc_tx_e;

    logic [15:0] pt_reg;
    logic pass_reg;
    logic en_reg;
    logic bp_reg;
    logic [31:0] rdata_reg;
    mpfc_tx_e st_reg, st_next;

    wire hit_flow = i_addr == ADDR_W'(FLOW_IDX);
    wire wr_flow = i_wr && hit_flow;
    wire rd_flow = i_rd && hit_flow;
    wire fd_busy = st_reg != TX_IDLE;
    wire busy_view = i_full_duplex ? fd_busy : bp_reg;
    wire [31:0] flow_view = {pt_reg, 13'h0000, pass_reg, en_reg, busy_view};

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pt_reg <= FLOW_RESET[PT_MSB:PT_LSB];
            pass_reg <= FLOW_RESET[PASS_BIT];
            en_reg <= FLOW_RESET[EN_BIT];
        end else if (wr_flow) begin
            // busy is hardware owned, written value ignored
            pt_reg <= i_wdata[PT_MSB:PT_LSB];
            pass_reg <= i_wdata[PASS_BIT];
            en_reg <= i_wdata[EN_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rd_flow ? flow_view : 32'h0000_0000;
        end
    end
    assign o_rdata = rdata_reg;

    // ------------------------------------------------------------
    // pause frame transmit
    // ------------------------------------------------------------
    logic req_d_reg;
    logic [5:0] idx_reg, idx_next;
    logic [15:0] snap_reg, snap_next;
    mpfc_tx_s tx_reg, tx_next;

    wire req_rise = i_auto_pause_config && !req_d_reg;
    wire start = st_reg == TX_IDLE && req_rise && i_full_duplex && i_tx_enable;
    wire accept = tx_reg.valid && i_tx_ready;
    wire [5:0] idx_inc = idx_reg + 6'h01;

    always_comb begin
        st_next = st_reg;
        idx_next = idx_reg;
        snap_next = snap_reg;
        tx_next = tx_reg;
        case (st_reg)
            TX_IDLE: begin
                if (start) begin
                    st_next = TX_SEND;
                    idx_next = 6'h00;
                    snap_next = pt_reg;
                    tx_next = '{valid: 1'b1, last: 1'b0, data: hdr_byte(6'h00)};
                end
            end
            TX_SEND: begin
                if (accept && tx_reg.last) begin
                    st_next = TX_WAIT;
                    tx_next = '0;
                end else if (accept) begin
                    idx_next = idx_inc;
                    tx_next.data = frame_byte(idx_inc, snap_reg, i_src_addr);
                    tx_next.last = idx_inc == FRAME_LAST;
                end
            end
            TX_WAIT: begin
                if (i_tx_done) begin
                    st_next = TX_IDLE;
                end
            end
            default: st_next = TX_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= TX_IDLE;
            idx_reg <= 6'h00;
            snap_reg <= 16'h0000;
            tx_reg <= '0;
            req_d_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            idx_reg <= idx_next;
            snap_reg <= snap_next;
            tx_reg <= tx_next;
            req_d_reg <= i_auto_pause_config;
        end
    end
    assign o_tx = tx_reg;

    // ------------------------------------------------------------
    // half-duplex back pressure
    // ------------------------------------------------------------
    wire bp_next = !i_full_duplex && en_reg && i_tx_enable && i_auto_pause_config;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bp_reg <= 1'b0;
        end else begin
            bp_reg <= bp_next;
        end
    end
    assign o_backpressure = bp_reg;

    // ------------------------------------------------------------
    // receive decode and status
    // ------------------------------------------------------------
    logic [5:0] rx_idx_reg;
    logic match_reg;
    logic [7:0] rxpt_hi_reg;
    logic [7:0] rxpt_lo_reg;
    logic [15:0] rxpt_reg;
    mpfc_rx_s fwd_reg;
    logic stat_v_reg;
    logic filt_reg;

    wire cmp_pos = rx_idx_reg < SA_POS || (rx_idx_reg >= TYPE_POS && rx_idx_reg < PT_POS);
    wire byte_ok = !cmp_pos || i_rx.data == hdr_byte(rx_idx_reg);
    wire match_next = (rx_idx_reg == 6'h00 || match_reg) && byte_ok;
    wire frame_end = i_rx.valid && i_rx.last;
    wire long_enough = rx_idx_reg > PT_POS;
    wire pause_valid = frame_end && i_rx.good && match_next && long_enough
        && en_reg && i_full_duplex;
    wire filt_next = i_filt_override ? i_addr_filt_bit
        : pause_valid ? pass_reg : i_addr_filt_bit;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_idx_reg <= 6'h00;
            match_reg <= 1'b0;
            rxpt_hi_reg <= 8'h00;
            rxpt_lo_reg <= 8'h00;
        end else if (i_rx.valid) begin
            rx_idx_reg <= i_rx.last ? 6'h00 : (rx_idx_reg == 6'h3f ? rx_idx_reg : rx_idx_reg + 6'h01);
            match_reg <= match_next;
            if (rx_idx_reg == PT_POS) begin
                rxpt_hi_reg <= i_rx.data;
            end
            if (rx_idx_reg == PT_POS + 6'h01) begin
                rxpt_lo_reg <= i_rx.data;
            end
        end
    end
    // low byte may still be on the bus when the frame ends on it
    wire rx_lo_now = rx_idx_reg == PT_POS + 6'h01;
    wire [15:0] rx_pt = {rxpt_hi_reg, rx_lo_now ? i_rx.data : rxpt_lo_reg};
    assign rxpt_reg = rx_pt;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fwd_reg <= '0;
            stat_v_reg <= 1'b0;
            filt_reg <= 1'b0;
        end else begin
            fwd_reg <= i_rx;
            stat_v_reg <= frame_end;
            filt_reg <= frame_end ? filt_next : filt_reg;
        end
    end
    assign o_rx_fwd = fwd_reg;
    assign o_rx_stat_valid = stat_v_reg;
    assign o_rx_pkt_filter = filt_reg;

    // ------------------------------------------------------------
    // pause halt timer
    // ------------------------------------------------------------
    logic [15:0] quanta_reg;
    logic [11:0] slot_reg;
    logic halt_reg;

    wire [11:0] slot_len = i_speed_100 ? SLOT_CYC_100 : SLOT_CYC_10;
    wire slot_end = slot_reg == slot_len - 12'h001;
    wire [15:0] quanta_next = !en_reg ? 16'h0000
        : pause_valid ? rxpt_reg
        : (quanta_reg != 16'h0000 && slot_end) ? quanta_reg - 16'h0001 : quanta_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            quanta_reg <= 16'h0000;
            slot_reg <= 12'h000;
            halt_reg <= 1'b0;
        end else begin
            quanta_reg <= quanta_next;
            slot_reg <= (pause_valid || slot_end || quanta_reg == 16'h0000) ? 12'h000 : slot_reg + 12'h001;
            halt_reg <= quanta_next != 16'h0000;
        end
    end
    assign o_tx_halt = halt_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_pt_field;
        o_tx.valid && idx_reg == PT_POS |-> o_tx.data == snap_reg[15:8];
    endproperty
    a_pt_field: assert property (p_pt_field) else $error("pause time byte wrong");
    property p_pt_snap;
        start |=> snap_reg == $past(pt_reg);
    endproperty
    a_pt_snap: assert property (p_pt_snap) else $error("pause time not captured");
    property p_hdr;
        o_tx.valid && (idx_reg < SA_POS || (idx_reg >= TYPE_POS && idx_reg < PT_POS))
            |-> o_tx.data == hdr_byte(idx_reg);
    endproperty
    a_hdr: assert property (p_hdr) else $error("pause frame header byte wrong");
    property p_busy_fd;
        i_full_duplex && st_reg != TX_IDLE |-> busy_view;
    endproperty
    a_busy_fd: assert property (p_busy_fd) else $error("busy low during pause frame");
    property p_busy_hd;
        !i_full_duplex |-> busy_view == o_backpressure;
    endproperty
    a_busy_hd: assert property (p_busy_hd) else $error("busy not following back pressure");
    property p_busy_clr;
        i_full_duplex && st_reg == TX_WAIT && i_tx_done ##1 i_full_duplex |-> !busy_view;
    endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared after frame");
    property p_filter;
        frame_end && pause_valid && !i_filt_override |=> o_rx_pkt_filter == $past(pass_reg);
    endproperty
    a_filter: assert property (p_filter) else $error("filter bit not from pass bit");
    property p_fwd;
        i_rx.valid |=> o_rx_fwd.valid && o_rx_fwd.data == $past(i_rx.data);
    endproperty
    a_fwd: assert property (p_fwd) else $error("received byte not forwarded");
    property p_override;
        frame_end && i_filt_override |=> o_rx_pkt_filter == $past(i_addr_filt_bit);
    endproperty
    a_override: assert property (p_override) else $error("filter mode did not win");
    property p_halt;
        pause_valid && rx_pt != 16'h0000 |=> o_tx_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt after pause frame");
    property p_no_halt;
        !en_reg |=> !o_tx_halt;
    endproperty
    a_no_halt: assert property (p_no_halt) else $error("halt while disabled");
    property p_bp;
        !i_full_duplex && en_reg && i_tx_enable && i_auto_pause_config |=> o_backpressure;
    endproperty
    a_bp: assert property (p_bp) else $error("back pressure missing");
    property p_txdis;
        !i_tx_enable && st_reg == TX_IDLE |=> st_reg == TX_IDLE && !o_backpressure;
    endproperty
    a_txdis: assert property (p_txdis) else $error("flow control with tx disabled");
    property p_reserved;
        o_rdata[15:3] == 13'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
    property p_count;
        en_reg && !pause_valid && quanta_reg != 16'h0000 && slot_end |=> quanta_reg == $past(quanta_reg) - 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("pause count not decremented");

    c_frame: cover property (st_reg == TX_WAIT ##1 st_reg == TX_IDLE);
    c_pause_rx: cover property (pause_valid ##1 o_tx_halt);
    c_bp: cover property (!i_full_duplex && o_backpressure);

endmodule : mpfc_flow_ctrl

// ### mpfc_pkg.sv
// constants and carrier types for the mac pause flow-control block
package mpfc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] FLOW_IDX = 4'h8;
    localparam logic [31:0] FLOW_RESET = 32'h0000_0000;
    localparam int PT_LSB = 16;
    localparam int PT_MSB = 31;
    localparam int PASS_BIT = 2;
    localparam int EN_BIT = 1;
    localparam int BUSY_BIT = 0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SLOT_BITS = 512;
    localparam int BIT_NS_100 = 10;
    localparam int BIT_NS_10 = 100;
    localparam logic [11:0] SLOT_CYC_100 =
        12'((SLOT_BITS * BIT_NS_100 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] SLOT_CYC_10 =
        12'((SLOT_BITS * BIT_NS_10 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // pause frame layout
    // ------------------------------------------------------------
    localparam logic [47:0] PAUSE_DA = 48'h01_80_c2_00_00_01;
    localparam logic [15:0] CTRL_TYPE = 16'h8808;
    localparam logic [15:0] PAUSE_OPC = 16'h0001;
    localparam logic [5:0] SA_POS = 6'h06;
    localparam logic [5:0] TYPE_POS = 6'h0c;
    localparam logic [5:0] OPC_POS = 6'h0e;
    localparam logic [5:0] PT_POS = 6'h10;
    localparam logic [5:0] FRAME_LAST = 6'h3b;

    typedef struct packed {
        logic valid;
        logic last;
        logic good;
        logic [7:0] data;
    } mpfc_rx_s;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } mpfc_tx_s;

endpackage : mpfc_pkg

// ### mpfc_link_partner.sv
// link partner model: pause frame sink and receive frame source
module mpfc_link_partner
    import mpfc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire mpfc_pkg::mpfc_tx_s i_tx,
    output logic o_tx_ready,
    output logic o_tx_done,
    output mpfc_pkg::mpfc_rx_s o_rx
);
    logic [7:0] cap [0:59];
    int n_cap;
    int n_done;
    int wait_cnt;

    initial o_rx = '0;

    function automatic logic [7:0] frame_byte(input int i, input logic [47:0] sa, input logic [15:0] pt);
        if (i < 6) return PAUSE_DA[47 - 8 * i -: 8];
        if (i < 12) return sa[47 - 8 * (i - 6) -: 8];
        if (i < 14) return CTRL_TYPE[15 - 8 * (i - 12) -: 8];
        if (i < 16) return PAUSE_OPC[15 - 8 * (i - 14) -: 8];
        if (i < 18) return pt[15 - 8 * (i - 16) -: 8];
        return 8'h00;
    endfunction : frame_byte

    // ------------------------------------------------------------
    // transmit sink, stalls every other cycle
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tx_ready <= 1'b0;
            o_tx_done <= 1'b0;
            n_cap <= 0;
            n_done <= 0;
            wait_cnt <= 0;
        end else begin
            o_tx_ready <= ~o_tx_ready;
            o_tx_done <= (wait_cnt == 1);
            if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
            if (o_tx_done) n_done <= n_done + 1;
            if (i_tx.valid && o_tx_ready && n_cap < 60) begin
                cap[n_cap] <= i_tx.data;
                n_cap <= i_tx.last ? 0 : n_cap + 1;
                if (i_tx.last) wait_cnt <= 6;
            end
        end
    end

    // ------------------------------------------------------------
    // receive source; idle data is the inverse of the last byte
    // ------------------------------------------------------------
    task automatic send_frame(input logic [15:0] pt, input logic good);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 60; i++) begin
            @(posedge i_clk);
            b = frame_byte(i, 48'h02_00_00_00_00_01, pt);
            o_rx <= '{1'b1, i == 59, good, b};
        end
        @(posedge i_clk);
        o_rx <= '{1'b0, 1'b0, 1'b0, ~b};
    endtask : send_frame
endmodule : mpfc_link_partner

// ### test_mac_pause_flow_control.sv
// self-checking bench for the pause flow-control unit
module test_mac_pause_flow_control;
    timeunit 1ns;
    timeprecision 100ps;
    import mpfc_pkg::*;

    logic clk;
    logic nrst;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic fd;
    logic tx_en;
    logic auto_req;
    logic ovr;
    logic afb;
    logic ready;
    logic done;
    logic stat_v;
    logic filt;
    logic halt;
    logic bp;
    logic seen;
    mpfc_tx_s tx;
    mpfc_rx_s rx;
    mpfc_rx_s rx_fwd;
    mpfc_rx_s rx_q = '0;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    int k;
    logic [31:0] rv;
    localparam logic [47:0] OWN_SA = 48'h0a_1b_2c_3d_4e_5f;
    localparam logic [3:0] REG_A [4] = '{4'h8, 4'h8, 4'h3, 4'h8};
    localparam logic [31:0] REG_W [4] = '{32'hffff_ffff, 32'h1234_0004, 32'hffff_ffff, 32'h0000_0000};
    localparam logic [31:0] REG_E [4] = '{32'hffff_0006, 32'h1234_0004, 32'h0000_0000, 32'h0000_0000};
    // pass, override, filter bit, enable, good | status filter, halt
    localparam logic [6:0] RX_T [5] = '{7'b1001111, 7'b0011101, 7'b0111111, 7'b1010110, 7'b1001000};

    mpfc_flow_ctrl mpfc_flow_ctrl_i (
        .i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_full_duplex(fd), .i_speed_100(1'b1), .i_tx_enable(tx_en),
        .i_auto_pause_config(auto_req), .i_src_addr(OWN_SA), .o_tx(tx), .i_tx_ready(ready),
        .i_tx_done(done), .i_rx(rx), .i_filt_override(ovr), .i_addr_filt_bit(afb),
        .o_rx_fwd(rx_fwd), .o_rx_stat_valid(stat_v), .o_rx_pkt_filter(filt),
        .o_tx_halt(halt), .o_backpressure(bp)
    );

    mpfc_link_partner mpfc_link_partner_i (
        .i_clk(clk), .i_nrst(nrst), .i_tx(tx), .o_tx_ready(ready), .o_tx_done(done), .o_rx(rx)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : reg_rd

    task automatic wait_halt_low;
        for (int i = 0; i < 3000 && halt !== 1'b0; i++) begin
            @(posedge clk);
        end
        chk({31'h0, halt}, 32'h0);
    endtask : wait_halt_low

    always @(posedge clk) begin
        if (nrst === 1'b1 && rx_q.valid === 1'b1) begin
            chk(32'(rx_fwd), 32'(rx_q));
        end
        rx_q <= rx;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        fd = 1'b1;
        tx_en = 1'b1;
        auto_req = 1'b0;
        ovr = 1'b0;
        afb = 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        reg_rd(FLOW_IDX, rv);
        chk(rv, FLOW_RESET);
        chk({28'h0, tx.valid, halt, bp, stat_v}, 32'h0);
        $display("reset test done");
        for (k = 0; k < 4; k++) begin
            reg_wr(REG_A[k], REG_W[k]);
            reg_rd(REG_A[k], rv);
            chk(rv, REG_E[k]);
        end
        $display("register rows done");
        reg_wr(FLOW_IDX, 32'h1234_0000);
        auto_req <= 1'b1;
        reg_rd(FLOW_IDX, rv);
        chk(rv, 32'h1234_0001);
        for (k = 0; k < 200 && rv[BUSY_BIT] !== 1'b0; k++) begin
            reg_rd(FLOW_IDX, rv);
        end
        chk(32'(mpfc_link_partner_i.n_done), 32'h1);
        for (k = 0; k < 60; k++) begin
            chk(32'(mpfc_link_partner_i.cap[k]), 32'(mpfc_link_partner_i.frame_byte(k, OWN_SA, 16'h1234)));
        end
        @(posedge clk);
        auto_req <= 1'b0;
        $display("pause transmit test done");
        for (k = 0; k < 5; k++) begin
            reg_wr(FLOW_IDX, {29'h0, RX_T[k][6], RX_T[k][3], 1'b0});
            ovr <= RX_T[k][5];
            afb <= RX_T[k][4];
            mpfc_link_partner_i.send_frame(16'h0001, RX_T[k][2]);
            @(negedge clk);
            chk({29'h0, stat_v, filt, halt}, {29'h0, 1'b1, RX_T[k][1:0]});
            wait_halt_low();
        end
        $display("receive rows done");
        reg_wr(FLOW_IDX, 32'h0000_0002);
        ovr <= 1'b0;
        mpfc_link_partner_i.send_frame(16'h0002, 1'b1);
        @(negedge clk);
        for (k = 0; k < 1000 && halt === 1'b1; k++) begin
            @(posedge clk);
        end
        chk(32'(k > 404 && k < 416), 32'h1);
        mpfc_link_partner_i.send_frame(16'h00c8, 1'b1);
        @(negedge clk);
        chk({31'h0, halt}, 32'h1);
        mpfc_link_partner_i.send_frame(16'h0000, 1'b1);
        @(negedge clk);
        chk({31'h0, halt}, 32'h0);
        $display("pause timing test done");
        @(posedge clk);
        fd <= 1'b0;
        auto_req <= 1'b1;
        repeat (3) @(posedge clk);
        reg_rd(FLOW_IDX, rv);
        chk(rv, 32'h0000_0003);
        chk({31'h0, bp}, 32'h1);
        @(posedge clk);
        tx_en <= 1'b0;
        repeat (3) @(posedge clk);
        reg_rd(FLOW_IDX, rv);
        chk({rv[BUSY_BIT], bp}, 32'h0);
        @(posedge clk);
        auto_req <= 1'b0;
        fd <= 1'b1;
        @(posedge clk);
        auto_req <= 1'b1;
        seen = 1'b0;
        repeat (20) begin
            @(posedge clk);
            seen = seen | tx.valid;
        end
        chk({31'h0, seen}, 32'h0);
        $display("half duplex and disabled transmitter test done");
        tally_and_finish();
    end
endmodule : test_mac_pause_flow_control
